//--- rtl/pab_regs.sv
`timescale 1ns/1ps
`include "pab_params.svh"

// Behaviour
// - ident bits 15:10 hold OUI, writable
// - ident bits 9:4 hold model, writable
// - ident bits 3:0 hold revision, writable
// - revision reset value is a parameter
// - advertise bit 13 remote fault, reset zero
// - advertise bits 11:10 pause code, reset 00
// - both pause kinds resolve to one mode
// - advertise ability bits 8..5, bit 7 resets one
// - bits 8,6 reset from mode straps, bit 5 loads one
// - selector bits 4:0 writable, reset 00001
// - partner bit 15 next page, unsupported locally
// - partner bit 14 set once word received
// - partner bit 13 shows partner remote fault
// - partner bit 10 shows partner pause
// - partner bit 9 reports T4, not local
// - partner bits 8:5 abilities, selector resets 00001
// - autoneg enable overrides manual speed, duplex
// - restart bit self-clears, restarts negotiation
module pab_regs
  import pab_pkg::*;
#(
  parameter logic [5:0] OUI_BITS = 6'h2A, // arbitrary identity value
  parameter logic [5:0] MODEL_NUM = 6'h15, // arbitrary identity value
  parameter logic [3:0] REV_NUM = 4'h1 // arbitrary identity value
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [2:0] mode_strap_i,
  input wire logic [15:0] rx_word_i,
  input wire logic rx_word_valid_i,
  input wire logic an_complete_i,
  output logic an_restart_o,
  output logic an_busy_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic pause_sym_o,
  output logic pause_asym_o
);

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic pab_word_t merge(input pab_word_t old_v,
                                      input pab_word_t new_v,
                                      input pab_word_t mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // ************************************************
  // strap capture and synchronised pins
  // ************************************************
  logic [2:0] strap_s;
  logic word_vld_s;
  logic done_s;
  logic strap_take_q;

  pab_sync #(.W(3)) u_strap_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(mode_strap_i),
    .q_o(strap_s)
  );

  pab_sync #(.W(2)) u_evt_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({rx_word_valid_i, an_complete_i}),
    .q_o({word_vld_s, done_s})
  );

  // the received word is held stable by its source while valid is high
  logic [15:0] word_s1_q;
  logic [15:0] word_s2_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_s1_q <= 16'h0000;
      word_s2_q <= 16'h0000;
    end else begin
      word_s1_q <= rx_word_i;
      word_s2_q <= word_s1_q;
    end
  end

  // strap load runs three cycles after release, once synchroniser settles
  logic [1:0] strap_cnt_q;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_q <= 2'h0;
      strap_take_q <= 1'b0;
    end else begin
      if (strap_cnt_q != 2'h3) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      strap_take_q <= (strap_cnt_q == 2'h2);
    end
  end

  // ************************************************
  // identification register
  // ************************************************
  logic [5:0] oui_q;
  logic [5:0] model_q;
  logic [3:0] rev_q;

  // organisation bits
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oui_q <= OUI_BITS;
    end else if (wr_i && hit(addr_i, `PAB_OFF_IDLO)) begin
      oui_q <= wdata_i[`PAB_ID_OUI_HI:`PAB_ID_OUI_LO];
    end
  end

  // model code
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      model_q <= MODEL_NUM;
    end else if (wr_i && hit(addr_i, `PAB_OFF_IDLO)) begin
      model_q <= wdata_i[`PAB_ID_MDL_HI:`PAB_ID_MDL_LO];
    end
  end

  // revision code, reset value chosen per build
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rev_q <= REV_NUM;
    end else if (wr_i && hit(addr_i, `PAB_OFF_IDLO)) begin
      rev_q <= wdata_i[`PAB_ID_REV_HI:`PAB_ID_REV_LO];
    end
  end

  // ************************************************
  // advertisement register
  // ************************************************
  pab_word_t adv_q;
  pab_word_t strap_adv;

  // mode straps: 1xx or 011 all capable; 001 adds 10M full duplex; 000, 010 half duplex only
  always_comb begin
    strap_adv = `PAB_ADV_FIXED_RST;
    strap_adv[`PAB_B_10] = 1'b1;
    strap_adv[`PAB_B_10FD] = strap_s[0] | strap_s[2];
    strap_adv[`PAB_B_TXFD] = strap_s[2] | (strap_s[1] & strap_s[0]);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adv_q <= `PAB_ADV_FIXED_RST;
    end else if (wr_i && hit(addr_i, `PAB_OFF_ADV)) begin
      adv_q <= merge(adv_q, wdata_i, `PAB_ADV_WMASK);
    end else if (strap_take_q) begin
      adv_q <= strap_adv;
    end
  end

  // ************************************************
  // control: enable, restart, manual speed and duplex
  // ************************************************
  pab_word_t ctrl_q;
  logic restart_req;

  assign restart_req = wr_i && hit(addr_i, `PAB_OFF_CTRL) &&
                       wdata_i[`PAB_C_RESTART];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `PAB_CTRL_RST;
    end else if (wr_i && hit(addr_i, `PAB_OFF_CTRL)) begin
      ctrl_q <= merge(ctrl_q, wdata_i, `PAB_CTRL_WMASK);
    end
  end

  // ************************************************
  // negotiation sequencing
  // ************************************************
  pab_an_state_t an_q;
  pab_word_t lpa_q;
  logic sym_c;
  logic asym_c;

  pab_pause_res u_pause (
    .local_i(adv_q[`PAB_B_PAUSE_HI:`PAB_B_PAUSE_LO]),
    .partner_i(lpa_q[`PAB_B_PAUSE_LO]),
    .sym_o(sym_c),
    .asym_o(asym_c)
  );

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      an_q <= PAB_AN_IDLE;
    end else begin
      case (an_q)
        PAB_AN_IDLE: begin
          if (restart_req || strap_take_q) begin
            an_q <= PAB_AN_WAIT;
          end
        end
        PAB_AN_WAIT: begin
          if (done_s) begin
            an_q <= PAB_AN_DONE;
          end
        end
        PAB_AN_DONE: begin
          if (restart_req) begin
            an_q <= PAB_AN_WAIT;
          end
        end
        default: an_q <= PAB_AN_IDLE;
      endcase
    end
  end

  // restart reads back zero: it is never stored, only pulsed
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      an_restart_o <= 1'b0;
      an_busy_o <= 1'b0;
    end else begin
      an_restart_o <= restart_req && ctrl_q[`PAB_C_ANEN];
      an_busy_o <= (an_q == PAB_AN_WAIT);
    end
  end

  // resolved speed and duplex: negotiated result overrides manual bits
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
    end else if (!ctrl_q[`PAB_C_ANEN]) begin
      speed_100_o <= ctrl_q[`PAB_C_SPEED];
      full_duplex_o <= ctrl_q[`PAB_C_DUPLEX];
    end else if (an_q == PAB_AN_DONE) begin
      speed_100_o <= (adv_q[`PAB_B_TX] & lpa_q[`PAB_B_TX]) |
                     (adv_q[`PAB_B_TXFD] & lpa_q[`PAB_B_TXFD]);
      full_duplex_o <= (adv_q[`PAB_B_TXFD] & lpa_q[`PAB_B_TXFD]) |
                       (adv_q[`PAB_B_10FD] & lpa_q[`PAB_B_10FD] &
                        ~(adv_q[`PAB_B_TX] & lpa_q[`PAB_B_TX]));
    end
  end

  // pause mode only while negotiation is on and complete
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pause_sym_o <= 1'b0;
      pause_asym_o <= 1'b0;
    end else if (ctrl_q[`PAB_C_ANEN] && (an_q == PAB_AN_DONE)) begin
      pause_sym_o <= sym_c;
      pause_asym_o <= asym_c;
    end else begin
      pause_sym_o <= 1'b0;
      pause_asym_o <= 1'b0;
    end
  end

  // ************************************************
  // partner ability register
  // ************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lpa_q <= `PAB_LPA_RST;
    end else if (word_vld_s) begin
      // ack forced: a word has arrived; arrival wins over a restart
      lpa_q <= (word_s2_q & `PAB_LPA_RMASK) |
               (16'h0001 << `PAB_B_ACK);
    end else if (restart_req) begin
      lpa_q <= `PAB_LPA_RST;
    end
  end

  // ************************************************
  // read port
  // ************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `PAB_OFF_CTRL: rdata_o <= ctrl_q;
        `PAB_OFF_IDLO: rdata_o <= {oui_q, model_q, rev_q};
        `PAB_OFF_ADV: rdata_o <= adv_q & `PAB_ADV_WMASK;
        `PAB_OFF_LPA: rdata_o <= lpa_q;
        `PAB_OFF_NEG: rdata_o <= {11'h000, an_q == PAB_AN_DONE,
                                  pause_sym_o, pause_asym_o,
                                  speed_100_o, full_duplex_o};
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule : pab_regs

//--- rtl/pab_params.svh
`ifndef PAB_PARAMS_SVH
`define PAB_PARAMS_SVH

// register indices
`define PAB_OFF_CTRL 5'h00
`define PAB_OFF_IDLO 5'h03
`define PAB_OFF_ADV 5'h04
`define PAB_OFF_LPA 5'h05
`define PAB_OFF_NEG 5'h10

// ident fields
`define PAB_ID_OUI_HI 15
`define PAB_ID_OUI_LO 10
`define PAB_ID_MDL_HI 9
`define PAB_ID_MDL_LO 4
`define PAB_ID_REV_HI 3
`define PAB_ID_REV_LO 0

// advertisement and partner fields
`define PAB_B_NP 15
`define PAB_B_ACK 14
`define PAB_B_RF 13
`define PAB_B_PAUSE_HI 11
`define PAB_B_PAUSE_LO 10
`define PAB_B_T4 9
`define PAB_B_TXFD 8
`define PAB_B_TX 7
`define PAB_B_10FD 6
`define PAB_B_10 5
`define PAB_B_SEL_HI 4
`define PAB_B_SEL_LO 0

// control fields
`define PAB_C_ANEN 12
`define PAB_C_RESTART 9
`define PAB_C_SPEED 13
`define PAB_C_DUPLEX 8

// masks of writable and received bits
`define PAB_ADV_WMASK 16'h2DFF
`define PAB_LPA_RMASK 16'hE7FF
`define PAB_CTRL_WMASK 16'h3100

// reset values
`define PAB_SEL_RST 5'h01
`define PAB_ADV_FIXED_RST 16'h0081
`define PAB_LPA_RST 16'h0001
`define PAB_CTRL_RST 16'h1000

`endif

//--- rtl/pab_pkg.sv
package pab_pkg;

  typedef logic [15:0] pab_word_t;

  typedef enum logic [2:0] {
    PAB_AN_IDLE = 3'b001,
    PAB_AN_WAIT = 3'b010,
    PAB_AN_DONE = 3'b100
  } pab_an_state_t;

endpackage : pab_pkg

//--- rtl/pab_sync.sv
`timescale 1ns/1ps

// ************************************************
// two-flop synchroniser for pin levels
// ************************************************
module pab_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : pab_sync

//--- rtl/pab_pause_res.sv
`timescale 1ns/1ps

// ************************************************
// pause resolution at negotiation completion
// ************************************************
module pab_pause_res (
  input wire logic [1:0] local_i,
  input wire logic partner_i,
  output logic sym_o,
  output logic asym_o
);

  // never both modes at once
  always_comb begin
    sym_o = 1'b0;
    asym_o = 1'b0;
    if (local_i[0] && partner_i) begin
      sym_o = 1'b1;
    end else if (local_i[1]) begin
      asym_o = 1'b1;
    end
  end

endmodule : pab_pause_res

//--- tb/pab_regs_sva.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module pab_regs_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic an_restart_o,
  input wire logic pause_sym_o,
  input wire logic pause_asym_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  a_idle_read: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside answer");
  a_restart_on_write: assert property (
    wr_i && addr_i == 5'h00 && wdata_i[9] && wdata_i[12] |=> an_restart_o)
    else $error("restart not pulsed");
  a_restart_pulse: assert property (an_restart_o |=> !an_restart_o)
    else $error("restart pulse too long");
  a_ctrl_selfclr: assert property (
    rd_i && addr_i == 5'h00 |=> !rdata_o[9])
    else $error("restart bit reads one");
  a_pause_one: assert property (!(pause_sym_o && pause_asym_o))
    else $error("both pause modes set");
  a_unmapped_zero: assert property (
    rd_i && addr_i == 5'h1F |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_adv_rsvd: assert property (
    rd_i && addr_i == 5'h04 |=> (rdata_o & 16'hD200) == 16'h0000)
    else $error("advertise reserved bits set");
  a_lpa_rsvd: assert property (
    rd_i && addr_i == 5'h05 |=> rdata_o[12:11] == 2'h0)
    else $error("partner reserved bits set");
  a_lpa_ack: assert property (
    rd_i && addr_i == 5'h05 ##1 rdata_o != 16'h0001 |-> rdata_o[14])
    else $error("partner word without acknowledge");
  c_restart: cover property (an_restart_o);
  c_sym: cover property (pause_sym_o);
  c_asym: cover property (pause_asym_o);
endmodule : pab_regs_sva

bind pab_regs pab_regs_sva chk (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .an_restart_o, .pause_sym_o, .pause_asym_o);

//--- tb/pab_link_partner.sv
`timescale 1ns/1ps
// ****
// remote partner: base word, then completion
// ****
module pab_link_partner
  import pab_pkg::*;
(
  input wire logic ref_clk_i,
  output pab_word_t rx_word_o,
  output logic rx_word_valid_o,
  output logic an_complete_o
);
  initial begin
    rx_word_o = 16'h0000;
    rx_word_valid_o = 1'h0;
    an_complete_o = 1'h0;
  end
  task automatic send(input pab_word_t w, input int hold);
    @(posedge ref_clk_i);
    rx_word_o <= w;
    rx_word_valid_o <= 1'h1;
    repeat (hold) @(posedge ref_clk_i);
    rx_word_valid_o <= 1'h0;
    // released word is not left on the line
    rx_word_o <= ~w;
    repeat (2) @(posedge ref_clk_i);
    an_complete_o <= 1'h1;
  endtask : send
  task automatic drop();
    @(posedge ref_clk_i);
    an_complete_o <= 1'h0;
  endtask : drop
endmodule : pab_link_partner

//--- tb/tb.sv
`timescale 1ns/1ps
// ****
// register slice bench
// ****
module tb
  import pab_pkg::*;
;
  logic ref_clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0;
  logic rd_d = 1'h0, rx_valid, an_cmpl, an_restart_o, an_busy_o;
  logic spd, fdx, psym, pasym;
  logic [4:0] addr_i = 5'h00;
  logic [2:0] strap = 3'h0;
  logic [4:0] tab [7] = '{5'h0E, 5'h1E, 5'h19, 5'h11, 5'h15, 5'h04, 5'h08};
  pab_word_t wdata_i = 16'h0000, rdata_o, rx_word, w;
  pab_word_t exp_q [$];
  int err_total = 0, n_checks = 0, cyc = 0, n_restart = 0;
  integer seed = 32'hA65E4A64;

  initial forever #5 ref_clk_i = ~ref_clk_i;

  pab_regs DUT (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .mode_strap_i(strap), .rx_word_i(rx_word), .rx_word_valid_i(rx_valid),
    .an_complete_i(an_cmpl), .an_restart_o, .an_busy_o, .speed_100_o(spd),
    .full_duplex_o(fdx), .pause_sym_o(psym), .pause_asym_o(pasym));
  pab_link_partner lp (.ref_clk_i, .rx_word_o(rx_word),
    .rx_word_valid_o(rx_valid), .an_complete_o(an_cmpl));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input pab_word_t got, input pab_word_t exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one strobe per call; a read notes its expected answer
  task automatic bus(input logic wr, input logic [4:0] a, input pab_word_t d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= wr;
    rd_i <= ~wr;
    if (!wr) exp_q.push_back(d);
    @(posedge ref_clk_i);
  endtask : bus
  task automatic idle(input int n);
    wr_i <= 1'h0;
    rd_i <= 1'h0;
    repeat (n) @(posedge ref_clk_i);
  endtask : idle
  task automatic do_reset(input logic [2:0] s);
    rst_i <= 1'h1;
    strap <= s;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    repeat (5) @(posedge ref_clk_i);
  endtask : do_reset
  function automatic pab_word_t adv_rst(input logic [2:0] s);
    return {7'h00, s[2] | (s[1] & s[0]), 1'h1, s[0] | s[2], 6'h21};
  endfunction : adv_rst

  always @(posedge ref_clk_i) begin
    rd_d <= rd_i;
    if (an_restart_o) n_restart <= n_restart + 1;
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  always @(negedge ref_clk_i) begin
    if (rd_d && exp_q.size() > 0) chk(rdata_o, exp_q.pop_front());
  end

  initial begin : main
    for (int i = 0; i < 3; i++) begin
      do_reset(3'(i + 1));
      bus(1'h0, 5'h03, 16'hA951);
      bus(1'h0, 5'h04, adv_rst(strap));
      bus(1'h0, 5'h05, 16'h0001);
      bus(1'h0, 5'h1F, 16'h0000);
      idle(2);
      $display("reset test %0d done", i);
    end
    for (int i = 0; i < 8; i++) begin
      w = $random(seed);
      bus(1'h1, 5'h03, w);
      bus(1'h0, 5'h03, w);
      bus(1'h1, 5'h04, ~w);
      bus(1'h0, 5'h04, ~w & 16'h2DFF);
    end
    idle(2);
    $display("write test done");
    foreach (tab[k]) begin
      lp.drop();
      idle(3);
      bus(1'h1, 5'h04, {4'h0, tab[k][4:3], 10'h1E1});
      bus(1'h1, 5'h00, 16'h1200);
      bus(1'h0, 5'h00, 16'h1000);
      bus(1'h0, 5'h05, 16'h0001);
      idle(1);
      w = ($random(seed) & 16'hFBFF) | {5'h00, tab[k][2], 10'h000};
      lp.send(w, 3 + k % 3);
      repeat (8) @(posedge ref_clk_i);
      bus(1'h0, 5'h05, (w & 16'hE7FF) | 16'h4000);
      bus(1'h1, 5'h05, 16'hFFFF);
      bus(1'h0, 5'h05, (w & 16'hE7FF) | 16'h4000);
      idle(2);
      @(negedge ref_clk_i);
      chk(n_restart, k + 1);
      chk(spd, w[8] | w[7]);
      chk(fdx, w[8] | (w[6] & ~w[7]));
      chk(psym, tab[k][1]);
      chk(pasym, tab[k][0]);
      chk(an_busy_o, 1'h0);
      $display("pause test %0d done", k);
    end
    report_and_stop();
  end
endmodule : tb
